// ---- inc/okc_params.svh ----
// constants of the converter supervisory control block
`ifndef OKC_PARAMS_SVH
`define OKC_PARAMS_SVH
`define OKC_A_ONOFF     8'h00
`define OKC_A_OPER      8'h04
`define OKC_A_VCMD      8'h08
`define OKC_A_TRIM      8'h0c
`define OKC_A_VMAX      8'h10
`define OKC_A_MHI       8'h14
`define OKC_A_MLO       8'h18
`define OKC_A_OVLIM     8'h1c
`define OKC_A_UVLIM     8'h20
`define OKC_A_PGON      8'h24
`define OKC_A_PGDLY     8'h28
`define OKC_A_VFCFG     8'h2c
`define OKC_A_OCRESP    8'h30
`define OKC_A_VENDOR    8'h34
`define OKC_A_ACOMP     8'h38
`define OKC_A_CLEAR     8'h3c
`define OKC_A_STATUS    8'h40
`define OKC_RST_ONOFF   4'h0
`define OKC_RST_OPER    8'h00
`define OKC_RST_VFCFG   3'h5
`define OKC_RST_OCRESP  5'h0d
`define OKC_RST_ACOMP   2'h3
`define OKC_RST_PGDLY   16'h0000
`define OKC_SRC_PIN     2'h0
`define OKC_SRC_CMD     2'h1
`define OKC_SRC_BOTH    2'h2
`define OKC_RSP_LATCH   2'h0
`define OKC_RSP_RETRY   2'h2
`define OKC_MRG_LOW     2'h1
`define OKC_MRG_HIGH    2'h2
`define OKC_OPER_ON     7
`define OKC_PCT_CEIL    8'h6e
`define OKC_PCT_OV      8'h73
`define OKC_PCT_UV      8'h55
`define OKC_PCT_PGON    8'h5a
`define OKC_PCT_MHI     8'h69
`define OKC_PCT_MLO     8'h5f
`define OKC_BAND_0      16'h03dc
`define OKC_BAND_1      16'h0567
`define OKC_BAND_2      16'h07b7
`define OKC_BAND_3      16'h095e
`define OKC_BAND_4      16'h0b93
`define OKC_CAP_0       16'h04b0
`define OKC_CAP_1       16'h06a4
`define OKC_CAP_2       16'h09c4
`define OKC_CAP_3       16'h0b9a
`define OKC_CAP_4       16'h0e60
`define OKC_CAP_5       16'h1229
`define OKC_TICK_NS     50
`define OKC_US_NS       1000
`define OKC_TICK_CYC    (`OKC_US_NS / `OKC_TICK_NS)
`define OKC_HICCUP_US   1000
`endif

// ---- inc/okc_pkg.sv ----
// types of the converter supervisory control block
package okc_pkg;
  typedef enum logic [4:0] {
    OKC_OFF   = 5'h01,
    OKC_RAMP  = 5'h02,
    OKC_RUN   = 5'h04,
    OKC_WAIT  = 5'h08,
    OKC_LATCH = 5'h10
  } okc_state_type;

  typedef struct packed {
    okc_state_type st;
    logic [3:0]  onoff;
    logic [7:0]  oper;
    logic [15:0] vcmd;
    logic        vcmd_set;
    logic [15:0] trim;
    logic [15:0] vmax;
    logic [15:0] mhi;
    logic [15:0] mlo;
    logic [15:0] ovlim;
    logic [15:0] uvlim;
    logic [15:0] pgon;
    logic [15:0] pgdly;
    logic [2:0]  vfcfg;
    logic [4:0]  ocresp;
    logic [1:0]  vendor;
    logic [1:0]  acomp;
    logic [2:0]  flags;
    logic [15:0] strap;
    logic        strap_ok;
    logic        en_d;
    logic [15:0] cap;
    logic [4:0]  pre;
    logic [15:0] tmr;
    logic [2:0]  tries;
    logic        ov_trip;
    logic [15:0] pgcnt;
    logic        pg;
    logic        reg_en;
    logic [15:0] setpt;
    logic        crowbar;
    logic        softstop;
    logic        pg_out;
    logic        pg_oe;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } okc_regs_type;
endpackage : okc_pkg

// ---- rtl/okc_supervisor.sv ----
// supervisory enable, setpoint, fault and power-good logic of a point-of-load converter
`timescale 1ns/100ps
`include "okc_params.svh"
module okc_supervisor #(
  parameter int HICCUP_CYC = `OKC_HICCUP_US * `OKC_TICK_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  input  wire logic        enable_pin_in,
  input  wire logic        overcurrent_in,
  input  wire logic [15:0] strap_mv_in,
  input  wire logic [15:0] vout_mv_in,
  input  wire logic        ramp_done_in,
  input  wire logic        tuning_done_in,
  output logic             regulate_en_out,
  output logic [15:0]      setpoint_mv_out,
  output logic             crowbar_out,
  output logic             soft_stop_out,
  output logic             output_ok_pin_out,
  output logic             output_ok_pin_oe_out
);
  okc_pkg::okc_regs_type r, n;
  logic [1:0] en_sync_r;
  logic [1:0] oc_sync_r;

  function automatic logic [15:0] pct(input logic [15:0] v, input logic [7:0] p);
    logic [23:0] t;
    t   = 24'(v) * 24'(p);
    pct = 16'(t / 24'd100);
  endfunction : pct

  function automatic logic [15:0] band_cap(input logic [15:0] v);
    if (v <= `OKC_BAND_0) begin
      band_cap = `OKC_CAP_0;
    end else if (v <= `OKC_BAND_1) begin
      band_cap = `OKC_CAP_1;
    end else if (v <= `OKC_BAND_2) begin
      band_cap = `OKC_CAP_2;
    end else if (v <= `OKC_BAND_3) begin
      band_cap = `OKC_CAP_3;
    end else if (v <= `OKC_BAND_4) begin
      band_cap = `OKC_CAP_4;
    end else begin
      band_cap = `OKC_CAP_5;
    end
  endfunction : band_cap

  function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] m);
    lim = (v > m) ? m : v;
  endfunction : lim

  // enable and overcurrent pins pass two flops
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      en_sync_r <= 2'h0;
      oc_sync_r <= 2'h0;
    end else begin
      en_sync_r <= {en_sync_r[0], enable_pin_in};
      oc_sync_r <= {oc_sync_r[0], overcurrent_in};
    end
  end

  logic        pin_on;
  logic        en_req;
  logic [15:0] nominal;
  logic [16:0] trimmed;
  logic [15:0] ceiling;
  logic [15:0] target;
  logic [15:0] ov_lvl;
  logic [15:0] uv_lvl;
  logic [15:0] pgon_lvl;
  logic        ov_hit;
  logic        uv_hit;
  logic        oc_hit;
  logic        fault;
  logic [1:0]  rsp;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [31:0] rdat;
  logic        clr;
  logic        tick;

  always_comb begin
    n = r;
    pin_on = en_sync_r[1] ^ r.onoff[2];
    case (r.onoff[1:0])
      `OKC_SRC_PIN:  en_req = pin_on;
      `OKC_SRC_CMD:  en_req = r.oper[`OKC_OPER_ON];
      `OKC_SRC_BOTH: en_req = pin_on & r.oper[`OKC_OPER_ON];
      default:       en_req = 1'b1;
    endcase
    nominal = r.vcmd_set ? r.vcmd : r.strap;
    trimmed = {1'b0, nominal};
    if (!r.vendor[1]) begin
      trimmed = 17'({1'b0, nominal} + {r.trim[15], r.trim});
    end
    if (trimmed[16]) begin
      trimmed = 17'h0;
    end
    // margin overrides independent of the enable source
    case (r.oper[5:4])
      `OKC_MRG_HIGH: target = (r.mhi != 16'h0) ? r.mhi : pct(nominal, `OKC_PCT_MHI);
      `OKC_MRG_LOW:  target = (r.mlo != 16'h0) ? r.mlo : pct(nominal, `OKC_PCT_MLO);
      default:       target = trimmed[15:0];
    endcase
    ceiling = pct(r.strap, `OKC_PCT_CEIL);
    if (r.vmax != 16'h0) begin
      ceiling = lim(ceiling, r.vmax);
    end
    target = lim(target, ceiling);
    if (r.reg_en) begin
      target = lim(target, r.cap);
    end
    ov_lvl   = (r.ovlim != 16'h0) ? r.ovlim : pct(nominal, `OKC_PCT_OV);
    uv_lvl   = (r.uvlim != 16'h0) ? r.uvlim : pct(nominal, `OKC_PCT_UV);
    pgon_lvl = (r.pgon != 16'h0) ? r.pgon : pct(nominal, `OKC_PCT_PGON);
    ov_hit = r.reg_en & (vout_mv_in > ov_lvl);
    uv_hit = (r.st == okc_pkg::OKC_RUN) & (vout_mv_in < uv_lvl);
    oc_hit = (r.st == okc_pkg::OKC_RUN) & oc_sync_r[1];
    fault  = ov_hit | uv_hit | oc_hit;

    // microsecond tick for the delay counters
    tick  = (r.pre == 5'(`OKC_TICK_CYC - 1));
    n.pre = tick ? 5'h0 : 5'(r.pre + 5'h1);

    // strap value caught once after reset release
    if (!r.strap_ok) begin
      n.strap    = strap_mv_in;
      n.strap_ok = 1'b1;
    end

    // apb slave, one wait state per access
    wr   = psel_in & penable_in & !r.pready & pwrite_in;
    rd   = psel_in & penable_in & !r.pready & !pwrite_in;
    hit  = 1'b1;
    rdat = 32'h0;
    clr  = 1'b0;
    n.pready  = psel_in & penable_in & !r.pready;
    n.pslverr = 1'b0;
    if (paddr_in == `OKC_A_ONOFF) begin
      rdat = 32'(r.onoff);
      if (wr) n.onoff = pwdata_in[3:0];
    end else if (paddr_in == `OKC_A_OPER) begin
      rdat = 32'(r.oper);
      if (wr) n.oper = pwdata_in[7:0];
    end else if (paddr_in == `OKC_A_VCMD) begin
      rdat = 32'(nominal);
      if (wr) begin
        n.vcmd     = pwdata_in[15:0];
        n.vcmd_set = 1'b1;
      end
    end else if (paddr_in == `OKC_A_TRIM) begin
      rdat = 32'(r.trim);
      if (wr) n.trim = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_VMAX) begin
      rdat = 32'(r.vmax);
      if (wr) n.vmax = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_MHI) begin
      rdat = 32'(r.mhi);
      if (wr) n.mhi = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_MLO) begin
      rdat = 32'(r.mlo);
      if (wr) n.mlo = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_OVLIM) begin
      rdat = 32'(r.ovlim);
      if (wr) n.ovlim = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_UVLIM) begin
      rdat = 32'(r.uvlim);
      if (wr) n.uvlim = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_PGON) begin
      rdat = 32'(r.pgon);
      if (wr) n.pgon = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_PGDLY) begin
      rdat = 32'(r.pgdly);
      if (wr) n.pgdly = pwdata_in[15:0];
    end else if (paddr_in == `OKC_A_VFCFG) begin
      rdat = 32'(r.vfcfg);
      if (wr) n.vfcfg = pwdata_in[2:0];
    end else if (paddr_in == `OKC_A_OCRESP) begin
      rdat = 32'(r.ocresp);
      if (wr) n.ocresp = pwdata_in[4:0];
    end else if (paddr_in == `OKC_A_VENDOR) begin
      rdat = 32'(r.vendor);
      if (wr) n.vendor = pwdata_in[1:0];
    end else if (paddr_in == `OKC_A_ACOMP) begin
      rdat = 32'(r.acomp);
      if (wr) n.acomp = pwdata_in[1:0];
    end else if (paddr_in == `OKC_A_CLEAR) begin
      clr = wr;
    end else if (paddr_in == `OKC_A_STATUS) begin
      rdat = {24'h0, r.pg, r.st, r.flags[2:1] == 2'h0 ? r.flags[0] : 1'b1, r.crowbar};
      rdat = {16'h0, 5'h0, r.flags, r.pg, r.reg_en, 1'b0, r.st};
    end else begin
      hit = 1'b0;
    end
    if (n.pready) begin
      n.prdata  = rd ? rdat : r.prdata;
      n.pslverr = !hit;
    end

    // sticky flags: a new fault wins over clear
    if (clr) begin
      n.flags = 3'h0;
    end
    n.flags = n.flags | {oc_hit, uv_hit, ov_hit};

    n.en_d = en_req;
    n.tmr  = (tick && r.tmr != 16'h0) ? 16'(r.tmr - 16'h1) : r.tmr;
    rsp    = ov_hit ? r.vfcfg[1:0] : (uv_hit ? r.vfcfg[1:0] : r.ocresp[1:0]);
    if (!oc_hit && rsp == `OKC_RSP_RETRY) begin
      rsp = ~`OKC_RSP_LATCH;
    end
    case (r.st)
      okc_pkg::OKC_OFF: begin
        n.crowbar = n.crowbar & !en_req;
        if (en_req && r.strap_ok) begin
          n.st      = okc_pkg::OKC_RAMP;
          n.cap     = band_cap(target);
          n.crowbar = 1'b0;
        end
      end
      okc_pkg::OKC_RAMP, okc_pkg::OKC_RUN: begin
        if (r.st == okc_pkg::OKC_RAMP && ramp_done_in) begin
          n.st = okc_pkg::OKC_RUN;
        end
        if (!en_req) begin
          n.st = okc_pkg::OKC_OFF;
          n.tries = 3'h0;
        end else if (fault) begin
          n.crowbar = ov_hit & r.vfcfg[2];
          n.tmr     = 16'(HICCUP_CYC / `OKC_TICK_CYC);
          if (rsp == `OKC_RSP_LATCH) begin
            n.st = okc_pkg::OKC_LATCH;
          end else if (rsp == `OKC_RSP_RETRY && r.tries >= r.ocresp[4:2]) begin
            n.st = okc_pkg::OKC_LATCH;
          end else begin
            n.st    = okc_pkg::OKC_WAIT;
            n.tries = (rsp == `OKC_RSP_RETRY) ? 3'(r.tries + 3'h1) : r.tries;
          end
        end
      end
      okc_pkg::OKC_WAIT: begin
        if (!en_req) begin
          n.st    = okc_pkg::OKC_OFF;
          n.tries = 3'h0;
        end else if (r.tmr == 16'h0) begin
          n.st      = okc_pkg::OKC_RAMP;
          n.crowbar = 1'b0;
          n.cap     = band_cap(target);
        end
      end
      okc_pkg::OKC_LATCH: begin
        // released by clear faults or by dropping the enable
        if (clr || (en_req && !r.en_d) || !en_req) begin
          n.st    = okc_pkg::OKC_OFF;
          n.tries = 3'h0;
        end
      end
      default: n.st = okc_pkg::OKC_OFF;
    endcase
    n.reg_en   = (n.st == okc_pkg::OKC_RAMP) | (n.st == okc_pkg::OKC_RUN);
    n.setpt    = n.reg_en ? target : 16'h0;
    n.softstop = r.onoff[3];

    // power good
    if (r.st != okc_pkg::OKC_RUN || fault || r.flags != 3'h0) begin
      n.pg    = 1'b0;
      n.pgcnt = r.pgdly;
    end else if (r.pg) begin
      n.pg = !(vout_mv_in < uv_lvl);
      n.pgcnt = r.pgdly;
    end else if (vout_mv_in > pgon_lvl) begin
      if (r.acomp[0] && r.acomp[1]) begin
        n.pg = tuning_done_in;
      end else if (r.pgcnt == 16'h0) begin
        n.pg = 1'b1;
      end else if (tick) begin
        n.pgcnt = 16'(r.pgcnt - 16'h1);
      end
    end else begin
      n.pgcnt = r.pgdly;
    end
    n.pg_out = r.vendor[0] ? n.pg : 1'b0;
    n.pg_oe  = r.vendor[0] ? 1'b1 : !n.pg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r          <= '0;
      r.st       <= okc_pkg::OKC_OFF;
      r.onoff    <= `OKC_RST_ONOFF;
      r.oper     <= `OKC_RST_OPER;
      r.vfcfg    <= `OKC_RST_VFCFG;
      r.ocresp   <= `OKC_RST_OCRESP;
      r.acomp    <= `OKC_RST_ACOMP;
      r.pgdly    <= `OKC_RST_PGDLY;
      r.pg_oe    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign pready_out           = r.pready;
  assign prdata_out           = r.prdata;
  assign pslverr_out          = r.pslverr;
  assign regulate_en_out      = r.reg_en;
  assign setpoint_mv_out      = r.setpt;
  assign crowbar_out          = r.crowbar;
  assign soft_stop_out        = r.softstop;
  assign output_ok_pin_out    = r.pg_out;
  assign output_ok_pin_oe_out = r.pg_oe;
endmodule : okc_supervisor

// ---- verification/okc_chk.sv ----
// concurrent checks on the supervisor ports
`timescale 1ns/100ps
module okc_chk #(
  parameter int HICCUP_CYC = 40
) (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [15:0] strap_mv_in,
  input wire logic        regulate_en_out,
  input wire logic [15:0] setpoint_mv_out,
  input wire logic        crowbar_out,
  input wire logic        soft_stop_out,
  input wire logic        output_ok_pin_out,
  input wire logic        output_ok_pin_oe_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  logic wr_onoff;
  assign wr_onoff = psel_in & penable_in & pwrite_in & pready_out & (paddr_in == 8'h00);
  AST_APB_WAIT:
  assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("no answer after wait state");
  AST_PREADY_ONE:
  assert property (pready_out |=> !pready_out) else $error("pready held too long");
  AST_SLVERR_READY:
  assert property (pslverr_out |-> pready_out) else $error("error without pready");
  AST_SETPT_OFF:
  assert property (!regulate_en_out |-> setpoint_mv_out == 16'h0000) else $error("setpoint while disabled");
  AST_CEIL:
  assert property (32'(setpoint_mv_out) * 32'h64 <= 32'(strap_mv_in) * 32'h6e) else $error("setpoint above ceiling");
  AST_CROWBAR:
  assert property (crowbar_out |-> !regulate_en_out) else $error("crowbar while regulating");
  AST_PG_LOW:
  assert property (!regulate_en_out && $past(!regulate_en_out) |-> output_ok_pin_oe_out && !output_ok_pin_out)
    else $error("power good while off");
  AST_RESET_REL:
  assert property ($fell(rst_in) |-> !regulate_en_out && output_ok_pin_oe_out && !crowbar_out)
    else $error("outputs wrong after reset");
  AST_SOFTSTOP:
  assert property ($changed(soft_stop_out) |-> $past(wr_onoff) || $past(wr_onoff, 2))
    else $error("soft stop changed without write");
endmodule : okc_chk

// ---- verification/okc_plant.sv ----
// power stage model: output follows the setpoint, ramp completes after a fixed time
`timescale 1ns/100ps
module okc_plant (
  input  wire logic        clk_sys_in,
  input  wire logic        regulate_en_in,
  input  wire logic [15:0] setpoint_mv_in,
  input  wire logic [7:0]  vout_pct_in,
  output logic [15:0]      vout_mv_out,
  output logic             ramp_done_out
);
  logic [3:0] ramp_cnt_r;
  always_ff @(posedge clk_sys_in) begin
    if (!regulate_en_in) begin
      ramp_cnt_r <= 4'h0;
    end else if (ramp_cnt_r != 4'hf) begin
      ramp_cnt_r <= ramp_cnt_r + 4'h1;
    end
  end
  assign ramp_done_out = (ramp_cnt_r == 4'hf);
  // measured output is a bench-chosen percentage of the target
  assign vout_mv_out = 16'((32'(setpoint_mv_in) * 32'(vout_pct_in)) / 32'h64);
endmodule : okc_plant

// ---- verification/tb_top.sv ----
// self-checking bench of the converter supervisor
`timescale 1ns/100ps
module tb_top;
  localparam int HC = 40;
  logic        clk, rst, psel, pen, pwr, pin, oc, tune, e;
  logic        pready, pslverr, regen, crow, sstop, pg, pg_oe, rdone, pgw;
  logic [7:0]  paddr, pct;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] setpt, vout;
  int          miscompares = 0;
  int          comparisons = 0;
  assign pgw = pg_oe ? pg : 1'h1;
  okc_supervisor #(.HICCUP_CYC(HC)) dut (.clk_sys_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .enable_pin_in(pin), .overcurrent_in(oc),
    .strap_mv_in(16'h03e8), .vout_mv_in(vout), .ramp_done_in(rdone), .tuning_done_in(tune),
    .regulate_en_out(regen), .setpoint_mv_out(setpt), .crowbar_out(crow), .soft_stop_out(sstop),
    .output_ok_pin_out(pg), .output_ok_pin_oe_out(pg_oe));
  okc_plant u_plant (.clk_sys_in(clk), .regulate_en_in(regen), .setpoint_mv_in(setpt),
    .vout_pct_in(pct), .vout_mv_out(vout), .ramp_done_out(rdone));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) begin
      miscompares++;
      $display("wrong value pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(nm, x, q);
  endtask : rdc
  task automatic flag(input int b, input logic x);
    apb(1'h0, 8'h40, 32'h0);
    chk("status", x, q[b]);
  endtask : flag
  task automatic wen(input logic v, input int lim);
    int n;
    n = 0;
    while (regen !== v && n < lim) begin
      n++;
      @(posedge clk);
    end
    chk("regen", v, regen);
  endtask : wen
  task automatic t_defaults();
    rdc("onoff", 8'h00, 32'h0);
    rdc("vfcfg", 8'h2c, 32'h5);
    rdc("ocresp", 8'h30, 32'hd);
    rdc("acomp", 8'h38, 32'h3);
    rdc("vcmd", 8'h08, 32'h3e8);
    apb(1'h0, 8'h44, 32'h0);
    chk("slverr", 32'h1, e);
    wr(8'h00, 32'h8);
    cy(2);
    chk("softstop", 32'h1, sstop);
    wr(8'h00, 32'h0);
  endtask : t_defaults
  task automatic t_pin();
    pin <= 1'h1;
    wen(1'h1, 20);
    cy(4);
    chk("setpt", 32'h3e8, setpt);
    chk("pg ramp", 32'h0, pgw);
    cy(20);
    chk("pg untuned", 32'h0, pgw);
    tune <= 1'h1;
    cy(6);
    chk("pg od", 32'h1, pgw);
    chk("pg od oe", 32'h0, pg_oe);
    pin <= 1'h0;
    wen(1'h0, 20);
    chk("setpt off", 32'h0, setpt);
  endtask : t_pin
  task automatic t_src();
    wr(8'h00, 32'h4);
    wen(1'h1, 20);
    pin <= 1'h1;
    wen(1'h0, 20);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h80);
    wen(1'h1, 20);
    wr(8'h04, 32'ha0);
    cy(3);
    chk("mhi", 32'h41a, setpt);
    wr(8'h04, 32'h90);
    cy(3);
    chk("mlo", 32'h3b6, setpt);
    wr(8'h00, 32'h2);
    wen(1'h1, 20);
    pin <= 1'h0;
    wen(1'h0, 20);
    wr(8'h00, 32'h3);
    wen(1'h1, 20);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h20);
    pin <= 1'h1;
    wen(1'h1, 20);
    cy(3);
    chk("mhi pin", 32'h41a, setpt);
    wr(8'h04, 32'h0);
  endtask : t_src
  task automatic t_setpt();
    wr(8'h20, 32'h1f4);
    wr(8'h1c, 32'hbb8);
    wr(8'h08, 32'h7d0);
    rdc("vcmd", 8'h08, 32'h7d0);
    chk("ceil", 32'h44c, setpt);
    wr(8'h10, 32'h41a);
    cy(3);
    chk("vmax lo", 32'h41a, setpt);
    wr(8'h10, 32'h4b0);
    cy(3);
    chk("vmax hi", 32'h44c, setpt);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h384);
    wr(8'h0c, 32'h14);
    cy(3);
    chk("trim up", 32'h398, setpt);
    wr(8'h0c, 32'hffec);
    cy(3);
    chk("trim dn", 32'h370, setpt);
    wr(8'h34, 32'h2);
    cy(3);
    chk("trim share", 32'h384, setpt);
    wr(8'h34, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h3e8);
    wr(8'h20, 32'h0);
    wr(8'h1c, 32'h0);
  endtask : t_setpt
  task automatic t_ov();
    pct <= 8'h78;
    wen(1'h0, 20);
    cy(2);
    chk("crowbar", 32'h1, crow);
    pct <= 8'h64;
    flag(8, 1'h1);
    cy(20);
    chk("hiccup", 32'h0, regen);
    wen(1'h1, 40);
    flag(8, 1'h1);
    wr(8'h3c, 32'h0);
    flag(8, 1'h0);
    wr(8'h2c, 32'h0);
    pct <= 8'h78;
    wen(1'h0, 20);
    pct <= 8'h64;
    cy(80);
    chk("latched", 32'h0, regen);
    chk("no crowbar", 32'h0, crow);
    wr(8'h3c, 32'h0);
    wen(1'h1, 20);
    wr(8'h2c, 32'h5);
  endtask : t_ov
  task automatic t_uv();
    cy(30);
    pct <= 8'h50;
    wen(1'h0, 20);
    cy(1);
    chk("pg uv", 32'h0, pgw);
    flag(9, 1'h1);
    pct <= 8'h64;
    wen(1'h1, 60);
    wr(8'h3c, 32'h0);
  endtask : t_uv
  task automatic t_oc();
    logic p;
    int   n;
    wr(8'h30, 32'h6);
    pin <= 1'h0;
    wen(1'h0, 20);
    oc <= 1'h1;
    pin <= 1'h1;
    wen(1'h1, 20);
    cy(6);
    chk("oc unarmed", 32'h1, regen);
    wen(1'h0, 30);
    flag(10, 1'h1);
    n = 0;
    p = regen;
    repeat (300) begin
      @(posedge clk);
      if (regen === 1'h1 && p === 1'h0) n++;
      p = regen;
    end
    chk("oc retries", 32'h1, n);
    chk("oc latched", 32'h0, regen);
    oc <= 1'h0;
    wr(8'h3c, 32'h0);
    wr(8'h30, 32'hd);
    wen(1'h1, 20);
  endtask : t_oc
  task automatic t_pg();
    wr(8'h34, 32'h1);
    wr(8'h38, 32'h0);
    wr(8'h28, 32'h2);
    pin <= 1'h0;
    wen(1'h0, 20);
    pin <= 1'h1;
    wen(1'h1, 20);
    cy(30);
    chk("pg delay", 32'h0, pgw);
    cy(40);
    chk("pg pp", 32'h1, pg);
    chk("pg pp oe", 32'h1, pg_oe);
    pct <= 8'h54;
    cy(10);
    chk("pg off", 32'h0, pgw);
    pct <= 8'h64;
  endtask : t_pg
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    pen = 1'h0;
    pwr = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin = 1'h0;
    oc = 1'h0;
    tune = 1'h0;
    pct = 8'h64;
    cy(8);
    rst <= 1'h0;
    cy(1);
    t_defaults();
    t_pin();
    t_src();
    t_setpt();
    t_ov();
    t_uv();
    t_oc();
    t_pg();
    summarize();
  end
endmodule : tb_top
bind okc_supervisor okc_chk #(.HICCUP_CYC(HICCUP_CYC)) u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .strap_mv_in(strap_mv_in),
  .regulate_en_out(regulate_en_out), .setpoint_mv_out(setpoint_mv_out), .crowbar_out(crowbar_out),
  .soft_stop_out(soft_stop_out), .output_ok_pin_out(output_ok_pin_out),
  .output_ok_pin_oe_out(output_ok_pin_oe_out));
